// file: cac_map.svh
// register offsets, field positions, reset values and codes of the counter array
`ifndef CAC_MAP_SVH
`define CAC_MAP_SVH
// register offsets on the special function register port
`define CAC_STATUS_ADDR 8'hA5
`define CAC_CTRL1_ADDR 8'hBC
// per-channel blocks: base plus channel number 0..5
`define CAC_MODE_BASE 8'hC0
`define CAC_CMPL_BASE 8'hC8
`define CAC_CMPH_BASE 8'hD0
// reset values
`define CAC_STATUS_RST 8'h00
`define CAC_CTRL_RST 8'h00
`define CAC_MODE_RST 8'h00
`define CAC_CMP_RST 8'h00
// control fields
`define CAC_CTRL_RUN 6
`define CAC_CTRL_OVF_IE 5
`define CAC_CTRL_IDLE 4
`define CAC_CTRL_WIDE 2
`define CAC_CTRL_WMASK 8'h77
// status fields
`define CAC_ST_SECOND_ROLLOVER_FLAG 7
`define CAC_ST_FIRST_ROLLOVER_FLAG 3
`define CAC_ST_OVF_MASK 8'h88
// clock select codes
`define CAC_CLK_PRESCALE 2'h0
`define CAC_CLK_TIMER0 2'h1
`define CAC_CLK_EXT 2'h2
// pwm field codes
`define CAC_PWM_OFF 2'h0
`define CAC_PWM_FIX8 2'h1
`define CAC_PWM_PROG8 2'h2
`define CAC_PWM_WIDE 2'h3
// counter tops for the two widths
`define CAC_TOP16 16'hFFFF
`define CAC_TOP10 16'h03FF
`endif

// file: cac_pkg.sv
// types shared by the counter array control and its channels
package cac_pkg;
  // channel mode register layout, bit 7 first
  typedef struct packed {
    logic irq_enable;    // channel_irq_enable
    logic comp_enable;   // comparator enable
    logic rise_cap;      // rising_capture_enable
    logic fall_cap;      // falling_capture_enable
    logic match;         // match sets event flag
    logic toggle;        // invert pin on match
    logic [1:0] pwm;     // pwm variant
  } cac_mode_t;
  // counter control register layout, bit 7 first
  typedef struct packed {
    logic rsv7;          // reserved
    logic counter_run;
    logic overflow_irq_enable;
    logic idle_freeze;
    logic rsv3;          // reserved
    logic wide_pwm_select;
    logic [1:0] clk_sel;
  } cac_ctrl_t;
  // counter view handed to a channel
  typedef struct packed {
    logic [15:0] count;  // counter value after the step
    logic step;          // counter moved last cycle
    logic rollover;      // counter wrapped last cycle
    logic wide;          // 10-bit pwm selected
  } cac_cnt_t;
  // channel events back to the register side
  typedef struct packed {
    logic event_hit;     // match or capture event
    logic capture;       // capture the counter now
  } cac_evt_t;
endpackage : cac_pkg

// file: cac_channel.sv
// one capture/compare/pwm channel of the counter array
`include "cac_map.svh"
module cac_channel
  import cac_pkg::*;
(
  input wire logic sys_clk,       // cpu clock
  input wire logic reset,         // async reset, high
  input cac_mode_t mode,          // channel mode register
  input wire logic [15:0] compare,// compare value
  input cac_cnt_t cnt,            // counter view
  input wire logic pin_in,        // channel_pin level, async
  output cac_evt_t evt,           // registered events
  output logic pin_out,           // channel_pin drive level
  output logic pin_oe             // channel_pin drive enable
);
  logic pin_s1; // first sync stage, read by pin_s2 only
  logic pin_s2; // synchronised pin
  logic pin_prev; // previous synchronised level
  logic rise; // rising edge seen
  logic fall; // falling edge seen
  logic match_hit; // comparator equal on a counter step
  logic pwm_ge; // counter at or above duty threshold
  logic pwm_restart; // period end for pwm

  // pin synchroniser and edge history
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_prev <= 1'b0;
    end
    else
    begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
    end

  assign rise = pin_s2 & ~pin_prev;
  assign fall = ~pin_s2 & pin_prev;
  // comparator only fires while enabled, so a low-byte write mutes it
  assign match_hit = cnt.step & mode.comp_enable & (cnt.count == compare);

  // duty compare: 8-bit variants use the low counter byte against the high byte
  always_comb
  begin
    pwm_ge = 1'b0;
    pwm_restart = cnt.rollover;
    if (mode.pwm == `CAC_PWM_WIDE)
    begin
      if (cnt.wide)
        pwm_ge = cnt.count[9:0] >= compare[9:0];
      else
        pwm_ge = cnt.count >= compare;
    end
    else
    begin
      pwm_ge = cnt.count[7:0] >= compare[15:8];
      pwm_restart = cnt.step & (cnt.count[7:0] == 8'h00);
    end
  end

  // event pulses: capture on chosen edges, match when enabled
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      evt <= '0;
    else
    begin
      evt.capture <= (mode.rise_cap & rise) | (mode.fall_cap & fall);
      evt.event_hit <= (mode.rise_cap & rise) | (mode.fall_cap & fall)
                       | (match_hit & mode.match);
    end

  // pin drive: pwm has priority, else toggle on match
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      pin_oe <= (mode.pwm != `CAC_PWM_OFF) | (mode.toggle & mode.match);
      if (mode.pwm != `CAC_PWM_OFF)
      begin
        // high at threshold, low at wrap
        if (pwm_restart | ~mode.comp_enable)
          pin_out <= 1'b0;
        else if (cnt.step & pwm_ge)
          pin_out <= 1'b1;
      end
      else if (mode.toggle & mode.match & match_hit)
        pin_out <= ~pin_out;
    end
endmodule : cac_channel

// file: cac_counter_array.sv
// control, status and channel mode logic of the two-counter array
`include "cac_map.svh"
module cac_counter_array
  import cac_pkg::*;
#(
  parameter int CHANNELS = 6,      // channel count, three per counter
  parameter int COUNTERS = 2       // counter count
)
(
  input wire logic sys_clk,              // cpu clock, 10 MHz
  input wire logic reset,                // async reset, high
  input wire logic [7:0] sfr_addr,       // register address
  input wire logic [7:0] sfr_wdata,      // write data
  input wire logic sfr_wr,               // write strobe, one cycle
  input wire logic sfr_rd,               // read strobe, one cycle
  output logic [7:0] sfr_rdata,          // read data, held
  input wire logic [7:0] first_control,  // first counter control value
  input wire logic cpu_idle,             // cpu in idle mode
  input wire logic [1:0] prescale_tick,  // prescaler pulse per counter
  input wire logic timer0_overflow,      // timer 0 overflow pulse
  input wire logic [1:0] ext_clk_pin,    // external clock pins, async
  input wire logic [5:0] channel_pin_in, // channel pin levels, async
  output logic [5:0] channel_pin_out,    // channel pin drive levels
  output logic [5:0] channel_pin_oe,     // channel pin drive enables
  output logic irq                       // combined interrupt request
);
  // second counter control register
  cac_ctrl_t ctrl1;
  // control views of both counters
  cac_ctrl_t ctrl [COUNTERS];
  // status flags register
  logic [7:0] status;
  // hardware set requests into the status register
  logic [7:0] status_set;
  // per-channel mode, compare bytes and events
  cac_mode_t mode [CHANNELS];
  logic [7:0] cmp_lo [CHANNELS];
  logic [7:0] cmp_hi [CHANNELS];
  cac_evt_t evt [CHANNELS];
  // counter views handed to the channels
  cac_cnt_t cnt_view [COUNTERS];
  // interrupt enables lined up with status bits
  logic [7:0] irq_mask;
  // combinational read mux
  logic [7:0] next_rdata;
  // per-channel status bit positions: 0,1,2 then 4,5,6
  logic [7:0] chan_set;

  assign ctrl[0] = cac_ctrl_t'(first_control & `CAC_CTRL_WMASK);
  assign ctrl[1] = ctrl1;

  // second counter control register: reserved bits never stored
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      ctrl1 <= cac_ctrl_t'(`CAC_CTRL_RST);
    else if (sfr_wr && sfr_addr == `CAC_CTRL1_ADDR)
      ctrl1 <= cac_ctrl_t'(sfr_wdata & `CAC_CTRL_WMASK);

  // counters, one generate entry each
  genvar k;
  generate
    for (k = 0; k < COUNTERS; k++)
    begin : g_cnt
      logic ext_s1;        // first sync stage, read by ext_s2 only
      logic ext_s2;        // synchronised external clock
      logic ext_prev;      // previous level for edge detect
      logic src_tick;      // selected clock source pulse
      logic cnt_en;        // counter advances this cycle
      logic [15:0] count;  // counter value
      logic [15:0] top;    // wrap value for selected width
      logic step_q;        // counter moved last cycle
      logic wrap_q;        // counter wrapped last cycle

      // external clock pin sync; a rate up to a quarter of the
      // cpu clock keeps every edge visible through two stages
      always_ff @(posedge sys_clk or posedge reset)
        if (reset)
        begin
          ext_s1 <= 1'b0;
          ext_s2 <= 1'b0;
          ext_prev <= 1'b0;
        end
        else
        begin
          ext_s1 <= ext_clk_pin[k];
          ext_s2 <= ext_s1;
          ext_prev <= ext_s2;
        end

      // clock source select
      always_comb
      begin
        if (ctrl[k].clk_sel == `CAC_CLK_PRESCALE)
          src_tick = prescale_tick[k];
        else if (ctrl[k].clk_sel == `CAC_CLK_TIMER0)
          src_tick = timer0_overflow;
        else if (ctrl[k].clk_sel == `CAC_CLK_EXT)
          src_tick = ext_s2 & ~ext_prev;
        else
          src_tick = 1'b0; // unused code stops the counter
      end

      assign cnt_en = ctrl[k].counter_run & src_tick
                      & ~(ctrl[k].idle_freeze & cpu_idle);
      assign top = ctrl[k].wide_pwm_select ? `CAC_TOP10 : `CAC_TOP16;

      // counter with wrap at the selected top
      always_ff @(posedge sys_clk or posedge reset)
        if (reset)
        begin
          count <= 16'h0000;
          step_q <= 1'b0;
          wrap_q <= 1'b0;
        end
        else
        begin
          step_q <= cnt_en;
          wrap_q <= cnt_en & (count == top);
          if (cnt_en)
            count <= (count == top) ? 16'h0000 : count + 16'h0001;
        end

      // channels see the value after the step plus the pulses
      assign cnt_view[k] = '{count: count, step: step_q, rollover: wrap_q,
                             wide: ctrl[k].wide_pwm_select};
    end
  endgenerate

  // channels: mode and compare registers plus the channel logic
  genvar n;
  generate
    for (n = 0; n < CHANNELS; n++)
    begin : g_ch
      // counter that owns this channel
      localparam int OWNER = n / 3;
      logic low_wr;   // compare low byte written
      logic high_wr;  // compare high byte written
      logic mode_wr;  // mode register written

      assign mode_wr = sfr_wr && sfr_addr == `CAC_MODE_BASE + 8'(n);
      assign low_wr = sfr_wr && sfr_addr == `CAC_CMPL_BASE + 8'(n);
      assign high_wr = sfr_wr && sfr_addr == `CAC_CMPH_BASE + 8'(n);

      // mode register; compare byte writes steer the comparator enable
      always_ff @(posedge sys_clk or posedge reset)
        if (reset)
          mode[n] <= cac_mode_t'(`CAC_MODE_RST);
        else if (mode_wr)
          mode[n] <= cac_mode_t'(sfr_wdata);
        else if (low_wr)
          mode[n].comp_enable <= 1'b0;
        else if (high_wr)
          mode[n].comp_enable <= 1'b1;

      // compare bytes; a capture overwrites both with the counter,
      // and a software write in the same cycle loses to it
      always_ff @(posedge sys_clk or posedge reset)
        if (reset)
        begin
          cmp_lo[n] <= `CAC_CMP_RST;
          cmp_hi[n] <= `CAC_CMP_RST;
        end
        else if (evt[n].capture)
        begin
          cmp_lo[n] <= cnt_view[OWNER].count[7:0];
          cmp_hi[n] <= cnt_view[OWNER].count[15:8];
        end
        else
        begin
          if (low_wr)
            cmp_lo[n] <= sfr_wdata;
          if (high_wr)
            cmp_hi[n] <= sfr_wdata;
        end

      // channel logic
      cac_channel u_channel (
        .sys_clk(sys_clk),
        .reset(reset),
        .mode(mode[n]),
        .compare({cmp_hi[n], cmp_lo[n]}),
        .cnt(cnt_view[OWNER]),
        .pin_in(channel_pin_in[n]),
        .evt(evt[n]),
        .pin_out(channel_pin_out[n]),
        .pin_oe(channel_pin_oe[n])
      );

      assign chan_set[n < 3 ? n : n + 1] = evt[n].event_hit;
      assign irq_mask[n < 3 ? n : n + 1] = mode[n].irq_enable;
    end
  endgenerate

  // overflow flags sit at bits 3 and 7
  assign chan_set[`CAC_ST_FIRST_ROLLOVER_FLAG] = 1'b0;
  assign chan_set[`CAC_ST_SECOND_ROLLOVER_FLAG] = 1'b0;
  assign status_set = chan_set
                      | ({7'h00, cnt_view[0].rollover} << `CAC_ST_FIRST_ROLLOVER_FLAG)
                      | ({7'h00, cnt_view[1].rollover} << `CAC_ST_SECOND_ROLLOVER_FLAG);
  assign irq_mask[`CAC_ST_FIRST_ROLLOVER_FLAG] = ctrl[0].overflow_irq_enable;
  assign irq_mask[`CAC_ST_SECOND_ROLLOVER_FLAG] = ctrl[1].overflow_irq_enable;

  // status flags: a hardware set in the same cycle as a clearing
  // write wins, so no event is lost while software services another
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      status <= `CAC_STATUS_RST;
    else if (sfr_wr && sfr_addr == `CAC_STATUS_ADDR)
      status <= (status & sfr_wdata) | (sfr_wdata & `CAC_ST_OVF_MASK)
                | status_set;
    else
      status <= status | status_set;

  // combined request, registered so the output comes from a flop
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(status & irq_mask);

  // read decode; unmapped addresses return zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (sfr_addr == `CAC_STATUS_ADDR)
      next_rdata = status;
    else if (sfr_addr == `CAC_CTRL1_ADDR)
      next_rdata = ctrl1 & `CAC_CTRL_WMASK;
    else
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        if (sfr_addr == `CAC_MODE_BASE + 8'(i))
          next_rdata = mode[i];
        else if (sfr_addr == `CAC_CMPL_BASE + 8'(i))
          next_rdata = cmp_lo[i];
        else if (sfr_addr == `CAC_CMPH_BASE + 8'(i))
          next_rdata = cmp_hi[i];
      end
    end
  end

  // read data captured on the read strobe and held until the next
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
      sfr_rdata <= next_rdata;
endmodule : cac_counter_array

// file: cac_counter_array_checker.sv
// checker of the counter array register, interrupt and pin behaviour
`include "cac_map.svh"
module cac_counter_array_checker
  import cac_pkg::*;
(
  input wire logic sys_clk, // cpu clock
  input wire logic reset, // async reset, high
  input wire logic [7:0] sfr_addr, // register address
  input wire logic [7:0] sfr_wdata, // write data
  input wire logic sfr_wr, // write strobe
  input wire logic sfr_rd, // read strobe
  input wire logic [7:0] sfr_rdata, // read data
  input wire logic [7:0] first_control, // first counter control
  input wire logic [5:0] channel_pin_in, // pin levels
  input wire logic [5:0] channel_pin_oe, // pin drive enables
  input wire logic irq // combined request
);
  cac_mode_t mode_sh [6]; // mode registers as written
  logic [7:0] ctrl_sh; // second control as written
  logic [5:0] drv; // channel should drive its pin
  logic [5:0] rise_irq; // rising capture with interrupt
  logic [5:0] fall_irq; // falling capture with interrupt
  logic all_off; // no interrupt enable anywhere
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // shadows follow writes only; bit 6 moves by compare writes are not tracked
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_sh <= 8'h00;
      mode_sh <= '{default: '0};
    end
    else if (sfr_wr)
    begin
      if (sfr_addr == `CAC_CTRL1_ADDR)
        ctrl_sh <= sfr_wdata;
      for (int i = 0; i < 6; i++)
        if (sfr_addr == `CAC_MODE_BASE + 8'(i))
          mode_sh[i] <= cac_mode_t'(sfr_wdata);
    end
  end
  // per channel views derived from the shadows
  always_comb
  begin
    all_off = ~ctrl_sh[5] & ~first_control[5];
    for (int i = 0; i < 6; i++)
    begin
      drv[i] = (mode_sh[i].pwm != 2'h0) | (mode_sh[i].toggle & mode_sh[i].match);
      rise_irq[i] = mode_sh[i].irq_enable & mode_sh[i].rise_cap;
      fall_irq[i] = mode_sh[i].irq_enable & mode_sh[i].fall_cap;
      all_off = all_off & ~mode_sh[i].irq_enable;
    end
  end
  ctrl_readback_a: assert property (
    sfr_wr && sfr_addr == `CAC_CTRL1_ADDR ##1 sfr_rd && sfr_addr == `CAC_CTRL1_ADDR
    |=> sfr_rdata == ($past(sfr_wdata, 2) & `CAC_CTRL_WMASK))
    else $error("control readback differs");
  reserved_zero_a: assert property (
    sfr_rd && sfr_addr == `CAC_CTRL1_ADDR |=> !sfr_rdata[7] && !sfr_rdata[3])
    else $error("reserved control bit reads one");
  mode_readback_a: assert property (
    sfr_wr && sfr_addr[7:3] == 5'h18 && sfr_addr[2:0] < 3'h6
    ##1 sfr_rd && sfr_addr == $past(sfr_addr) |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("mode readback differs");
  ovf_soft_set_a: assert property (
    sfr_wr && sfr_addr == `CAC_STATUS_ADDR ##1 sfr_rd && sfr_addr == `CAC_STATUS_ADDR
    |=> (sfr_rdata & $past(sfr_wdata, 2) & 8'h88) == ($past(sfr_wdata, 2) & 8'h88))
    else $error("overflow flag not set by write");
  soft_irq_a: assert property (
    sfr_wr && sfr_addr == `CAC_STATUS_ADDR && sfr_wdata[7] && ctrl_sh[5] |-> ##[1:4] irq)
    else $error("enabled overflow gave no request");
  quiet_irq_a: assert property (
    all_off [*3] |-> !irq)
    else $error("request without any enable");
  pin_drive_a: assert property (
    drv == $past(drv) |-> channel_pin_oe == drv)
    else $error("pin drive enable differs from mode");
  rise_cap_a: assert property (
    |(channel_pin_in & ~$past(channel_pin_in) & rise_irq) |-> ##[2:10] irq)
    else $error("rising capture gave no request");
  fall_cap_a: assert property (
    |(~channel_pin_in & $past(channel_pin_in) & fall_irq) |-> ##[2:10] irq)
    else $error("falling capture gave no request");
  cover property (irq [*2]);
  cover property (|(channel_pin_in & ~$past(channel_pin_in) & rise_irq));
  cover property (|channel_pin_oe);
endmodule : cac_counter_array_checker

bind cac_counter_array cac_counter_array_checker u_checker (
  .sys_clk(sys_clk),
  .reset(reset),
  .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata),
  .first_control(first_control),
  .channel_pin_in(channel_pin_in),
  .channel_pin_oe(channel_pin_oe),
  .irq(irq)
);

// file: cac_pin_model.sv
// outside sources wired to the six channel pins
module cac_pin_model
  import cac_pkg::*;
(
  input wire logic [5:0] drive_level, // level the outside source applies
  input wire logic [5:0] pin_out, // level the block drives
  input wire logic [5:0] pin_oe, // block drive enables
  output logic [5:0] pin_wire // resolved pin level
);
  // edges come from the source; the block wins where it drives
  always_comb
    pin_wire = (pin_out & pin_oe) | (drive_level & ~pin_oe);
endmodule : cac_pin_model

// file: cac_counter_array_tb.sv
// self-checking bench for the counter array control and status block
`include "cac_map.svh"
module cac_counter_array_tb
  import cac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0; // cpu clock
  logic reset = 1'b1; // async reset
  logic [7:0] sfr_addr = 8'h00; // register address
  logic [7:0] sfr_wdata = 8'h00; // write data
  logic sfr_wr = 1'b0; // write strobe
  logic sfr_rd = 1'b0; // read strobe
  logic [7:0] sfr_rdata; // read data
  logic [7:0] first_control = 8'h00; // first counter control
  logic cpu_idle = 1'b0; // idle mode
  logic [1:0] prescale_tick = 2'h0; // prescaler pulses
  logic timer0_overflow = 1'b0; // timer 0 pulses
  logic [1:0] ext_clk_pin = 2'h0; // external clocks
  logic [5:0] channel_pin_in; // resolved pins
  logic [5:0] channel_pin_out; // block pin levels
  logic [5:0] channel_pin_oe; // block pin enables
  logic irq; // combined request
  logic [5:0] drive_level = 6'h00; // outside pin levels
  logic [1:0] src_sel = 2'h3; // active clock source, 3 for none
  logic [1:0] phase = 2'h0; // source pacing
  int err_total = 0; // mismatches
  int check_count = 0; // comparisons
  localparam logic [7:0] PAT [6] = '{8'h41, 8'h42, 8'h43, 8'h4C, 8'h30, 8'h90};
  localparam logic [7:0] CAPM [3] = '{8'hA0, 8'h90, 8'hB0};
  cac_counter_array DUT (.sys_clk(sys_clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .first_control(first_control), .cpu_idle(cpu_idle), .prescale_tick(prescale_tick),
    .timer0_overflow(timer0_overflow), .ext_clk_pin(ext_clk_pin),
    .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
    .channel_pin_oe(channel_pin_oe), .irq(irq));
  cac_pin_model PIN (.drive_level(drive_level), .pin_out(channel_pin_out),
    .pin_oe(channel_pin_oe), .pin_wire(channel_pin_in));
  always #50 sys_clk = ~sys_clk;
  // only the selected source pulses, so a wrong select never advances
  always @(posedge sys_clk)
  begin
    phase <= phase + 2'h1;
    prescale_tick <= {2{src_sel == 2'h0}};
    timer0_overflow <= (src_sel == 2'h1) && phase[0];
    ext_clk_pin <= {2{(src_sel == 2'h2) && phase[1]}};
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  // write leaves the strobe up; a read or an idle task lowers it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_rd <= 1'b0;
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_wr <= 1'b0;
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    @(posedge sys_clk);
    check(sfr_rdata, exp, "read");
  endtask : rd
  task automatic cyc(input int n);
    sfr_wr <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic irq_is(input logic e);
    check({7'h00, irq}, {7'h00, e}, "irq level");
  endtask : irq_is
  // bounded wait; running out counts and ends the run
  task automatic wait_irq(input int bound);
    int n = 0;
    // one edge always passes with the strobe low, so a preceding write is never repeated
    cyc(1);
    while (irq !== 1'b1 && n < bound)
    begin
      @(posedge sys_clk);
      n++;
    end
    irq_is(1'b1);
    if (irq !== 1'b1)
      conclude();
  endtask : wait_irq
  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(`CAC_STATUS_ADDR, `CAC_STATUS_RST);
    rd(`CAC_CTRL1_ADDR, `CAC_CTRL_RST);
    rd(8'h10, 8'h00);
    // every pwm code, toggle, capture and enable bit through the mode registers
    for (int i = 0; i < 6; i++)
    begin
      rd(`CAC_MODE_BASE + 8'(i), `CAC_MODE_RST);
      wr(`CAC_MODE_BASE + 8'(i), PAT[i]);
      rd(`CAC_MODE_BASE + 8'(i), PAT[i]);
    end
    cyc(2);
    check({2'h0, channel_pin_oe}, 8'h0F, "pin enables");
    for (int i = 0; i < 6; i++)
      wr(`CAC_MODE_BASE + 8'(i), 8'h00);
    cyc(3);
    check({2'h0, channel_pin_oe}, 8'h00, "pins released");
    wr(`CAC_CTRL1_ADDR, 8'hFF);
    rd(`CAC_CTRL1_ADDR, 8'h77);
    // software set and clear of the overflow flags, with and without enable
    wr(`CAC_CTRL1_ADDR, 8'h20);
    wr(`CAC_STATUS_ADDR, 8'h88);
    rd(`CAC_STATUS_ADDR, 8'h88);
    wait_irq(5);
    wr(`CAC_STATUS_ADDR, 8'h77);
    rd(`CAC_STATUS_ADDR, 8'h00);
    irq_is(1'b0);
    wr(`CAC_CTRL1_ADDR, 8'h00);
    wr(`CAC_STATUS_ADDR, 8'h80);
    cyc(5);
    irq_is(1'b0);
    first_control <= 8'h20;
    wr(`CAC_STATUS_ADDR, 8'h08);
    wait_irq(5);
    wr(`CAC_STATUS_ADDR, 8'h00);
    first_control <= 8'h00;
    // channel 0 match on the first counter: stopped, frozen, then running
    wr(`CAC_CMPL_BASE, 8'h05);
    wr(`CAC_CMPH_BASE, 8'h00);
    wr(`CAC_MODE_BASE, 8'hC8);
    src_sel <= 2'h0;
    cyc(20);
    irq_is(1'b0);
    first_control <= 8'h50;
    cpu_idle <= 1'b1;
    cyc(20);
    irq_is(1'b0);
    cpu_idle <= 1'b0;
    wait_irq(20);
    first_control <= 8'h00;
    rd(`CAC_STATUS_ADDR, 8'h01);
    wr(`CAC_STATUS_ADDR, 8'h00);
    wr(`CAC_MODE_BASE, 8'h00);
    // channel 3 capture: rising, falling, then both edges enabled and a rising edge driven
    wr(`CAC_CTRL1_ADDR, 8'h40);
    for (int k = 0; k < 3; k++)
    begin
      wr(`CAC_MODE_BASE + 8'h03, CAPM[k]);
      drive_level[3] <= ~drive_level[3];
      wait_irq(12);
      rd(`CAC_STATUS_ADDR, 8'h10);
      wr(`CAC_STATUS_ADDR, 8'h00);
      cyc(3);
      irq_is(1'b0);
    end
    wr(`CAC_MODE_BASE + 8'h03, 8'h00);
    // channel 1 wide pwm on the first counter: 16-bit compare 0400 keeps the pin low,
    // the 10-bit width sees only the low ten compare bits (zero) and drives it high
    wr(`CAC_CMPL_BASE + 8'h01, 8'h00);
    wr(`CAC_CMPH_BASE + 8'h01, 8'h04);
    wr(`CAC_MODE_BASE + 8'h01, 8'h43);
    rd(`CAC_CMPH_BASE + 8'h01, 8'h04);
    first_control <= 8'h40;
    cyc(6);
    check({7'h00, channel_pin_out[1]}, 8'h00, "pwm below threshold");
    first_control <= 8'h44;
    cyc(6);
    check({7'h00, channel_pin_out[1]}, 8'h01, "pwm at threshold");
    first_control <= 8'h00;
    wr(`CAC_MODE_BASE + 8'h01, 8'h00);
    // each clock source on its own, 10-bit wrap sets the overflow flag
    for (int k = 0; k < 3; k++)
    begin
      src_sel <= 2'(k);
      wr(`CAC_CTRL1_ADDR, 8'h64 | 8'(k));
      wait_irq(5000);
      rd(`CAC_STATUS_ADDR, 8'h80);
      wr(`CAC_STATUS_ADDR, 8'h00);
      cyc(3);
    end
    wr(`CAC_CTRL1_ADDR, 8'h00);
    cyc(2);
    conclude();
  end
endmodule : cac_counter_array_tb
